/* logic/rsm_pkg.sv */
`default_nettype none
package rsm_pkg;

  // Clock rate and the missing-clock window.
  localparam int unsigned CLK_PERIOD_NS          = 20;
  localparam int unsigned GAP_TIMEOUT_NS         = 100000;
  localparam int unsigned GAP_TIMEOUT_CYCLES_DEF = GAP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned GAP_CNT_W              = 16;
  localparam int unsigned GAP_HOLD_CYCLES        = 16;
  localparam int unsigned HOLD_CNT_W             = 5;

  // Register bus geometry and register byte offsets.
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;
  localparam logic [3:0]  CAUSE_OFS   = 4'h0;
  localparam logic [3:0]  REG_CTL_OFS = 4'h4;

  // Field positions in reset_cause_reg.
  localparam int unsigned CAUSE_PIN_BIT = 0;
  localparam int unsigned CAUSE_GAP_BIT = 2;
  localparam int unsigned CAUSE_CMP_BIT = 5;
  localparam int unsigned CAUSE_USB_BIT = 7;

  // Field positions in regulator_ctrl_reg.
  localparam int unsigned CTL_LOWPWR_BIT = 0;
  localparam int unsigned CTL_IRQEN_BIT  = 1;
  localparam int unsigned CTL_POL_BIT    = 5;
  localparam int unsigned CTL_STAT_BIT   = 6;
  localparam int unsigned CTL_VREG_BIT   = 7;

  // Reset values.
  localparam logic       GAP_EN_RST   = 1'b0;
  localparam logic       CMP_EN_RST   = 1'b0;
  localparam logic       USB_EN_RST   = 1'b0;
  localparam logic       IRQ_EN_RST   = 1'b0;
  localparam logic       POL_RST      = 1'b0;
  localparam logic       VREG_RST     = 1'b1;
  localparam logic       LOWPWR_RST   = 1'b0;
  localparam logic [3:0] CAUSE_RST    = 4'h0;
  localparam logic [3:0] SYNC_RST     = 4'h1;

  // Index of each source in the four-bit cause vector.
  localparam int unsigned SRC_PIN = 0;
  localparam int unsigned SRC_GAP = 1;
  localparam int unsigned SRC_CMP = 2;
  localparam int unsigned SRC_USB = 3;

  typedef enum logic [0:0] {RUN_S, HOLD_S} seq_state_t;

endpackage : rsm_pkg
`default_nettype wire

/* logic/level_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned W         = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_r <= RESET_VAL;
      q_out  <= RESET_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : level_sync
`default_nettype wire

/* logic/gap_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module gap_timer #(
  parameter int unsigned CNT_W   = 16,
  parameter int unsigned TIMEOUT = 5000
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic en_in,
  input  wire logic kick_in,
  output var  logic timeout_out
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire  logic       expire_w;

  assign expire_w = en_in & ~kick_in & (cnt_r == LAST);

  // A disabled detector or a fresh edge restarts the window; expiry restarts it too.
  always_comb
  begin
    if (!en_in || kick_in || expire_w)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + CNT_W'(1);
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r       <= '0;
      timeout_out <= 1'b0;
    end
    else
    begin
      cnt_r       <= cnt_nxt;
      timeout_out <= expire_w;
    end
  end

endmodule : gap_timer
`default_nettype wire

/* logic/reset_source_and_vbus_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_vbus_monitor #(
  parameter int unsigned GAP_TIMEOUT_CYCLES = rsm_pkg::GAP_TIMEOUT_CYCLES_DEF
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [rsm_pkg::ADDR_W-1:0] avs_address_in,
  input  wire logic                       avs_read_in,
  input  wire logic                       avs_write_in,
  input  wire logic [rsm_pkg::DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]                 avs_byteenable_in,
  output var  logic [rsm_pkg::DATA_W-1:0] avs_readdata_out,
  output var  logic                       avs_waitrequest_out,
  input  wire logic                       ext_reset_n_in,
  input  wire logic                       sys_clock_in,
  input  wire logic                       comparator_out_in,
  input  wire logic                       bus_power_in,
  output var  logic                       sys_reset_n_out,
  output var  logic                       bus_power_irq_out,
  output var  logic                       regulator_enable_out,
  output var  logic                       regulator_low_power_sel_out
);

  import rsm_pkg::*;

  // Places the four cause flags at their positions in reset_cause_reg.
  function automatic logic [DATA_W-1:0] cause_word(input logic [3:0] flags);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CAUSE_PIN_BIT] = flags[SRC_PIN];
    w[CAUSE_GAP_BIT] = flags[SRC_GAP];
    w[CAUSE_CMP_BIT] = flags[SRC_CMP];
    w[CAUSE_USB_BIT] = flags[SRC_USB];
    return w;
  endfunction : cause_word

  // True when the bus-power level equals the selected polarity.
  function automatic logic pol_match(input logic level, input logic pol);
    return level == pol;
  endfunction : pol_match

  // Places the regulator control fields at their positions in regulator_ctrl_reg.
  function automatic logic [DATA_W-1:0] ctl_word(input logic vreg,
                                                 input logic level,
                                                 input logic pol,
                                                 input logic irq_en,
                                                 input logic lowpwr);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CTL_VREG_BIT]   = vreg;
    w[CTL_STAT_BIT]   = level;
    w[CTL_POL_BIT]    = pol;
    w[CTL_IRQEN_BIT]  = irq_en;
    w[CTL_LOWPWR_BIT] = lowpwr;
    return w;
  endfunction : ctl_word

  logic [3:0]            sync_w;
  logic                  gap_timeout_w;
  logic                  sys_clock_d_r;
  logic                  gap_en_r;
  logic                  cmp_en_r;
  logic                  usb_en_r;
  logic                  irq_en_r;
  logic                  pol_r;
  logic [3:0]            cause_r;
  logic [3:0]            cause_nxt;
  logic [3:0]            flags_r;
  logic [3:0]            flags_nxt;
  logic [HOLD_CNT_W-1:0] hold_cnt_r;
  logic [HOLD_CNT_W-1:0] hold_cnt_nxt;
  logic                  wait_r;
  seq_state_t            state_r;
  seq_state_t            state_nxt;

  wire logic             pin_level_w;
  wire logic             sys_clock_w;
  wire logic             cmp_level_w;
  wire logic             vbus_level_w;
  wire logic             sys_clock_rise_w;
  wire logic             pin_src_w;
  wire logic             gap_src_w;
  wire logic             cmp_src_w;
  wire logic             usb_src_w;
  wire logic             any_src_w;
  wire logic [3:0]       cause_now_w;
  wire logic             req_w;
  wire logic             first_w;
  wire logic             commit_w;
  wire logic             lane0_w;
  wire logic             hit_cause_w;
  wire logic             hit_ctl_w;
  wire logic             wr_cause_w;
  wire logic             wr_ctl_w;
  wire logic [DATA_W-1:0] ctl_word_w;
  wire logic [DATA_W-1:0] read_word_w;

  // Every outside level, including the watched clock, is sampled twice first.
  level_sync #(
    .W         (4),
    .RESET_VAL (SYNC_RST)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({bus_power_in, comparator_out_in, sys_clock_in, ext_reset_n_in}),
    .q_out    (sync_w)
  );

  assign pin_level_w      = sync_w[0];
  assign sys_clock_w      = sync_w[1];
  assign cmp_level_w      = sync_w[2];
  assign vbus_level_w     = sync_w[3];
  assign sys_clock_rise_w = sys_clock_w & ~sys_clock_d_r;

  // The one-shot is retriggered by each rising edge of the watched clock.
  gap_timer #(
    .CNT_W   (GAP_CNT_W),
    .TIMEOUT (GAP_TIMEOUT_CYCLES)
  ) u_missing_clock_detector (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .en_in       (gap_en_r),
    .kick_in     (sys_clock_rise_w),
    .timeout_out (gap_timeout_w)
  );

  // Reset sources. The pin is only ever an input here, so internal resets cannot disturb it.
  assign pin_src_w = ~pin_level_w;
  assign gap_src_w = gap_timeout_w | (hold_cnt_r != '0);
  assign cmp_src_w = cmp_en_r & ~cmp_level_w;
  assign usb_src_w = usb_en_r & pol_match(vbus_level_w, pol_r);
  assign any_src_w = pin_src_w | gap_src_w | cmp_src_w | usb_src_w;

  // Of simultaneous causes only the first by priority, pin first, is recorded, so the flags stay one-hot.
  assign cause_now_w = pin_src_w ? 4'h1 :
                       gap_src_w ? 4'h2 :
                       cmp_src_w ? 4'h4 :
                       usb_src_w ? 4'h8 : 4'h0;

  // A timeout is a single pulse, so it is stretched to give the system a usable reset.
  always_comb
  begin
    if (gap_timeout_w)
      hold_cnt_nxt = HOLD_CNT_W'(GAP_HOLD_CYCLES - 1);
    else if (hold_cnt_r != '0)
      hold_cnt_nxt = hold_cnt_r - HOLD_CNT_W'(1);
    else
      hold_cnt_nxt = '0;
  end

  always_comb
  begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    flags_nxt = flags_r;
    unique case (state_r)
      RUN_S:
      begin
        if (any_src_w)
        begin
          state_nxt = HOLD_S;
          cause_nxt = cause_now_w;
        end
      end
      HOLD_S:
      begin
        if (!any_src_w)
        begin
          state_nxt = RUN_S;
          flags_nxt = cause_r;
        end
      end
    endcase
  end

  // Register bus: one wait cycle, then the answer stands for the accepting edge.
  assign req_w       = avs_read_in | avs_write_in;
  assign first_w     = req_w & wait_r;
  assign commit_w    = req_w & ~wait_r;
  assign lane0_w     = avs_byteenable_in[0];
  assign hit_cause_w = avs_address_in == CAUSE_OFS;
  assign hit_ctl_w   = avs_address_in == REG_CTL_OFS;
  assign wr_cause_w  = commit_w & avs_write_in & lane0_w & hit_cause_w;
  assign wr_ctl_w    = commit_w & avs_write_in & lane0_w & hit_ctl_w;

  assign ctl_word_w = ctl_word(regulator_enable_out,
                               vbus_level_w,
                               pol_r,
                               irq_en_r,
                               regulator_low_power_sel_out);

  // Unmapped addresses read as zero and ignore writes.
  assign read_word_w = hit_cause_w ? cause_word(flags_r) :
                       hit_ctl_w   ? ctl_word_w : '0;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wait_r           <= 1'b1;
      avs_readdata_out <= '0;
    end
    else
    begin
      wait_r <= wait_r ? ~req_w : 1'b1;
      if (first_w && avs_read_in)
        avs_readdata_out <= read_word_w;
    end
  end

  assign avs_waitrequest_out = wait_r;

  // Writes to reset_cause_reg set source enables; the flags read back are untouched.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      gap_en_r <= GAP_EN_RST;
      cmp_en_r <= CMP_EN_RST;
      usb_en_r <= USB_EN_RST;
    end
    else if (wr_cause_w)
    begin
      gap_en_r <= avs_writedata_in[CAUSE_GAP_BIT];
      cmp_en_r <= avs_writedata_in[CAUSE_CMP_BIT];
      usb_en_r <= avs_writedata_in[CAUSE_USB_BIT];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_en_r                    <= IRQ_EN_RST;
      pol_r                       <= POL_RST;
      regulator_enable_out        <= VREG_RST;
      regulator_low_power_sel_out <= LOWPWR_RST;
    end
    else if (wr_ctl_w)
    begin
      irq_en_r                    <= avs_writedata_in[CTL_IRQEN_BIT];
      pol_r                       <= avs_writedata_in[CTL_POL_BIT];
      regulator_enable_out        <= avs_writedata_in[CTL_VREG_BIT];
      regulator_low_power_sel_out <= avs_writedata_in[CTL_LOWPWR_BIT];
    end
  end

  // Flags change only on the way out of reset, so a read during reset still shows the previous cause.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= RUN_S;
      cause_r <= CAUSE_RST;
      flags_r <= CAUSE_RST;
    end
    else
    begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      hold_cnt_r    <= '0;
      sys_clock_d_r <= 1'b0;
    end
    else
    begin
      hold_cnt_r    <= hold_cnt_nxt;
      sys_clock_d_r <= sys_clock_w;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sys_reset_n_out   <= 1'b1;
      bus_power_irq_out <= 1'b0;
    end
    else
    begin
      sys_reset_n_out   <= state_nxt == RUN_S;
      bus_power_irq_out <= irq_en_r & pol_match(vbus_level_w, pol_r);
    end
  end

endmodule : reset_source_and_vbus_monitor
`default_nettype wire

/* test/rsm_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rsm_properties
  import rsm_pkg::*;
#(
  parameter int unsigned GAP_TIMEOUT_CYCLES = rsm_pkg::GAP_TIMEOUT_CYCLES_DEF
) (
  input wire logic                       clk_in,
  input wire logic                       rst_n_in,
  input wire logic [rsm_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic                       avs_read_in,
  input wire logic                       avs_write_in,
  input wire logic [rsm_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0]                 avs_byteenable_in,
  input wire logic [rsm_pkg::DATA_W-1:0] avs_readdata_out,
  input wire logic                       avs_waitrequest_out,
  input wire logic                       ext_reset_n_in,
  input wire logic                       sys_clock_in,
  input wire logic                       comparator_out_in,
  input wire logic                       bus_power_in,
  input wire logic                       sys_reset_n_out,
  input wire logic                       bus_power_irq_out,
  input wire logic                       regulator_enable_out,
  input wire logic                       regulator_low_power_sel_out
);
  logic        commit;
  logic        gap_en_r, cmp_en_r, usb_en_r, irq_en_r, pol_r, vreg_r, lowpwr_r, sclk_r;
  logic [2:0]  quiet_r;
  logic [15:0] gap_r;
  assign commit = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  // Mirror of the enables and control fields, snooped from committed writes.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      {gap_en_r, cmp_en_r, usb_en_r, irq_en_r, pol_r, vreg_r, lowpwr_r} <=
        {GAP_EN_RST, CMP_EN_RST, USB_EN_RST, IRQ_EN_RST, POL_RST, VREG_RST, LOWPWR_RST};
    else if (commit && avs_address_in == CAUSE_OFS)
      {gap_en_r, cmp_en_r, usb_en_r} <= {avs_writedata_in[2], avs_writedata_in[5], avs_writedata_in[7]};
    else if (commit && avs_address_in == REG_CTL_OFS)
      {irq_en_r, pol_r, vreg_r, lowpwr_r} <= {avs_writedata_in[1], avs_writedata_in[5:5], avs_writedata_in[7], avs_writedata_in[0]};
  end
  // Gap counts from the last rising watched-clock edge while the detector is on.
  always_ff @(posedge clk_in)
  begin
    sclk_r <= sys_clock_in;
    quiet_r <= (!rst_n_in || commit) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
    gap_r <= (!rst_n_in || !gap_en_r || (sys_clock_in && !sclk_r)) ? 16'h0 : gap_r + {15'h0, gap_r != 16'hffff};
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_pin_forces_reset: assert property (
    !ext_reset_n_in [*4] |-> !sys_reset_n_out) else $error("pin low without system reset");
  a_gap_timeout_reset: assert property (
    gap_r == GAP_TIMEOUT_CYCLES + 6 |-> !sys_reset_n_out) else $error("missing clock not reset");
  a_cmp_forces_reset: assert property (
    (cmp_en_r && !comparator_out_in) [*4] |-> !sys_reset_n_out) else $error("comparator not reset");
  a_usb_forces_reset: assert property (
    (usb_en_r && bus_power_in == pol_r) [*4] |-> !sys_reset_n_out) else $error("bus power not reset");
  a_irq_level_match: assert property (
    $stable(bus_power_in) [*4] ##0 (quiet_r > 3'h3) |-> bus_power_irq_out == (irq_en_r && bus_power_in == pol_r))
    else $error("interrupt level wrong");
  a_vreg_follows_write: assert property (
    quiet_r > 3'h2 |-> regulator_enable_out == vreg_r) else $error("regulator enable wrong");
  a_lowpwr_follows_write: assert property (
    quiet_r > 3'h2 |-> regulator_low_power_sel_out == lowpwr_r) else $error("low power select wrong");
  a_status_bit_live: assert property (
    $stable(bus_power_in) [*4] ##0 (avs_read_in && !avs_waitrequest_out && avs_address_in == REG_CTL_OFS)
    |-> avs_readdata_out[CTL_STAT_BIT] == bus_power_in) else $error("status bit wrong");
  a_cause_one_hot: assert property (
    avs_read_in && !avs_waitrequest_out && avs_address_in == CAUSE_OFS |-> $onehot0(avs_readdata_out))
    else $error("several cause flags set");
endmodule : rsm_properties
bind reset_source_and_vbus_monitor rsm_properties #(.GAP_TIMEOUT_CYCLES(GAP_TIMEOUT_CYCLES)) props_u (.*);
`default_nettype wire

/* test/reset_env_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_env_model (
  input  wire logic pin_low_in,
  input  wire logic cmp_low_in,
  input  wire logic vbus_in,
  input  wire logic clk_in,
  input  wire logic clk_stop_in,
  output var  logic ext_reset_n_out,
  output var  logic sys_clock_out,
  output var  logic comparator_out,
  output var  logic bus_power_out
);
  logic [2:0] div_r = 3'h0;
  // An eighth of clk_in, so each watched edge survives the synchroniser.
  always_ff @(posedge clk_in)
  begin
    if (!clk_stop_in)
      div_r <= div_r + 3'h1;
  end
  assign sys_clock_out = div_r[2];
  assign ext_reset_n_out = !pin_low_in;
  assign comparator_out = !cmp_low_in;
  assign bus_power_out = vbus_in;
endmodule : reset_env_model
`default_nettype wire

/* test/reset_source_and_vbus_monitor_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_vbus_monitor_bench;
  import rsm_pkg::*;
  localparam int unsigned GAP_T = 20;
  logic        clk_in = 1'b0;
  logic        rst_n, rd_q, wr_q, pin_low, cmp_low, vbus, clk_stop;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata;
  logic        wait_rq, ext_rst_n, sclk, cmp_o, vbus_o, sys_rst_n, irq, vreg, lowpwr;
  int          errors = 0;
  int          num_checks = 0;
  always #10 clk_in = ~clk_in;
  reset_env_model env_u (.pin_low_in(pin_low), .cmp_low_in(cmp_low), .vbus_in(vbus), .clk_in(clk_in),
    .clk_stop_in(clk_stop), .ext_reset_n_out(ext_rst_n), .sys_clock_out(sclk), .comparator_out(cmp_o),
    .bus_power_out(vbus_o));
  reset_source_and_vbus_monitor #(.GAP_TIMEOUT_CYCLES(GAP_T)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n),
    .avs_address_in(addr), .avs_read_in(rd_q), .avs_write_in(wr_q), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
    .ext_reset_n_in(ext_rst_n), .sys_clock_in(sclk), .comparator_out_in(cmp_o), .bus_power_in(vbus_o),
    .sys_reset_n_out(sys_rst_n), .bus_power_irq_out(irq), .regulator_enable_out(vreg),
    .regulator_low_power_sel_out(lowpwr));
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : check
  task automatic fail_wait();
    $display("ERROR at %0t: wait ran out", $time);
    errors++;
    give_verdict();
  endtask : fail_wait
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= a;
    wr_q <= w;
    rd_q <= !w;
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wait_rq !== 1'b0 && n < 50);
    q = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    if (wait_rq !== 1'b0)
      fail_wait();
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, exp});
  endtask : rd
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    while (sys_rst_n !== lvl && n < 300)
    begin
      @(posedge clk_in);
      n++;
    end
    if (sys_rst_n !== lvl)
      fail_wait();
  endtask : wait_rst
  initial
  begin
    {rst_n, rd_q, wr_q, pin_low, cmp_low, vbus, clk_stop} = 7'h00;
    addr = 4'h0;
    be = 4'hf;
    wdata = 32'h0;
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    check({28'h0, sys_rst_n, irq, vreg, lowpwr}, 32'ha);
    rd(REG_CTL_OFS, 8'h80);
    rd(CAUSE_OFS, 8'h00);
    rd(4'h8, 8'h00);
    wr(REG_CTL_OFS, 8'h01);
    cyc(2);
    check({30'h0, vreg, lowpwr}, 32'h1);
    be <= 4'h0;
    wr(REG_CTL_OFS, 8'h80);
    be <= 4'hf;
    rd(REG_CTL_OFS, 8'h01);
    wr(REG_CTL_OFS, 8'h80);
    vbus <= 1'b1;
    cyc(4);
    rd(REG_CTL_OFS, 8'hc0);
    for (int p = 0; p < 2; p++)
    begin
      wr(REG_CTL_OFS, p[0] ? 8'ha2 : 8'h82);
      for (int v = 0; v < 2; v++)
      begin
        vbus <= v[0];
        cyc(5);
        check({31'h0, irq}, {31'h0, v[0] == p[0]});
      end
    end
    wr(REG_CTL_OFS, 8'ha0);
    cyc(3);
    check({31'h0, irq}, 32'h0);
    wr(REG_CTL_OFS, 8'h80);
    pin_low <= 1'b1;
    cyc(6);
    check({31'h0, sys_rst_n}, 32'h0);
    pin_low <= 1'b0;
    wait_rst(1'b1);
    rd(CAUSE_OFS, 8'h01);
    wr(CAUSE_OFS, 8'h04);
    cyc(3 * GAP_T);
    check({31'h0, sys_rst_n}, 32'h1);
    clk_stop <= 1'b1;
    wait_rst(1'b0);
    clk_stop <= 1'b0;
    wait_rst(1'b1);
    rd(CAUSE_OFS, 8'h04);
    wr(CAUSE_OFS, 8'h00);
    clk_stop <= 1'b1;
    cyc(3 * GAP_T);
    check({31'h0, sys_rst_n}, 32'h1);
    clk_stop <= 1'b0;
    // The comparator output has already settled high before its reset is enabled.
    wr(CAUSE_OFS, 8'h20);
    cmp_low <= 1'b1;
    cyc(6);
    check({31'h0, sys_rst_n}, 32'h0);
    cmp_low <= 1'b0;
    wait_rst(1'b1);
    rd(CAUSE_OFS, 8'h20);
    wr(CAUSE_OFS, 8'h80);
    vbus <= 1'b0;
    cyc(6);
    check({31'h0, sys_rst_n}, 32'h0);
    vbus <= 1'b1;
    wait_rst(1'b1);
    rd(CAUSE_OFS, 8'h80);
    wr(CAUSE_OFS, 8'h00);
    give_verdict();
  end
endmodule : reset_source_and_vbus_monitor_bench
`default_nettype wire
